// >>> rtl/fmpc_top.sv
`timescale 1ns/1ps
// Function
// - Flag loop current low or high
// - Loop current flags drive alert
// - Two die temperature threshold flags
// - Only upper temperature flag alerts
// - Supply high flag, hysteresis, no alert
// - Supply low flag, hysteresis, alerts
// - Decode range straps, high-high repeats
// - Control bit eight selects converter input
// - Command byte starts one conversion
// - Fault read returns latest result
// - Control bit seven keeps converter powered
// - Decode regulator straps, seven settings
module fmpc_top (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog comparator levels, asynchronous
  input  wire logic        cmp_current_below,
  input  wire logic        cmp_current_above,
  input  wire logic        cmp_temp_lower,
  input  wire logic        cmp_temp_upper,
  input  wire logic        cmp_sense_below_0v6,
  input  wire logic        cmp_sense_above_0v7,
  input  wire logic        cmp_sense_below_0v3,
  input  wire logic        cmp_sense_above_0v4,
  // Converter interface
  input  wire logic [7:0]  adc_result,
  output logic             adc_power,
  output logic             adc_input_temp,
  output logic             adc_start,
  // Straps
  input  wire logic        range_strap_lsb,
  input  wire logic        range_strap_msb,
  input  wire logic        regulator_strap_bit0,
  input  wire logic        regulator_strap_bit1,
  input  wire logic        regulator_strap_bit2,
  output logic      [1:0]  loop_range,
  output logic      [2:0]  regulator_output,
  output logic             regulator_code_valid,
  // Alerts
  output logic             fault_alert,
  output logic             irq
);
  logic [7:0] cmp_sync;            // Synchronised comparator levels
  logic [5:0] flags;               // Fault flags
  logic [5:0] next_flags;
  logic [8:0] control;             // Control register
  logic [8:0] next_control;
  logic [5:0] status;              // Sticky events
  logic [5:0] next_status;
  logic [5:0] mask;                // Interrupt mask
  logic [5:0] next_mask;
  logic [7:0] result;              // Last conversion result
  logic [7:0] next_result;
  logic       next_fault_alert;
  fmpc_pkg::fmpc_state_e state, next_state;
  logic [7:0] conv_cnt;
  logic [7:0] next_conv_cnt;
  logic       wr_en;               // Write takes effect this edge
  logic       cmd_hit;             // Convert command written
  logic [5:0] rising;              // Flags newly set

  // Comparator levels pass through synchronisers before any flag logic
  fmpc_sync #(.W(8)) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .din     ({cmp_sense_above_0v4, cmp_sense_below_0v3, cmp_sense_above_0v7, cmp_sense_below_0v6,
                cmp_temp_upper, cmp_temp_lower, cmp_current_above, cmp_current_below}),
    .dout    (cmp_sync)
  );

  // Zero wait states; every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite;
  assign cmd_hit = wr_en && (paddr == fmpc_pkg::ADDR_COMMAND) && (pwdata[7:0] == fmpc_pkg::CMD_CONVERT);

  // Unmapped addresses answer with an error
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      if (paddr != fmpc_pkg::ADDR_FAULT && paddr != fmpc_pkg::ADDR_CONTROL &&
          paddr != fmpc_pkg::ADDR_COMMAND && paddr != fmpc_pkg::ADDR_STATUS &&
          paddr != fmpc_pkg::ADDR_MASK && paddr != fmpc_pkg::ADDR_STRAPS) begin
        pslverr = 1'b1;
      end
    end
  end

  // Read mux is combinational; prdata stays stable during the access phase
  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      if (paddr == fmpc_pkg::ADDR_FAULT) begin
        prdata = {16'h0000, result, 2'b00, flags};
      end else if (paddr == fmpc_pkg::ADDR_CONTROL) begin
        prdata = {23'h00_0000, control};
      end else if (paddr == fmpc_pkg::ADDR_STATUS) begin
        prdata = {26'h000_0000, status};
      end else if (paddr == fmpc_pkg::ADDR_MASK) begin
        prdata = {26'h000_0000, mask};
      end else if (paddr == fmpc_pkg::ADDR_STRAPS) begin
        // Range at 1:0, regulator code at 4:2, code valid at 5
        prdata = {26'h000_0000, regulator_code_valid, regulator_output, loop_range};
      end
    end
  end

  // Fault flags follow the comparators; supply flags hold between thresholds
  always_comb begin
    next_flags = flags;
    next_flags[fmpc_pkg::FLT_ILOW]  = cmp_sync[0];
    next_flags[fmpc_pkg::FLT_IHIGH] = cmp_sync[1];
    next_flags[fmpc_pkg::FLT_TLOW]  = cmp_sync[2];
    next_flags[fmpc_pkg::FLT_THIGH] = cmp_sync[3];
    if (cmp_sync[4]) begin
      next_flags[fmpc_pkg::FLT_SHIGH] = 1'b1;
    end else if (cmp_sync[5]) begin
      next_flags[fmpc_pkg::FLT_SHIGH] = 1'b0;
    end
    if (cmp_sync[6]) begin
      next_flags[fmpc_pkg::FLT_SLOW] = 1'b1;
    end else if (cmp_sync[7]) begin
      next_flags[fmpc_pkg::FLT_SLOW] = 1'b0;
    end
    // Registered OR of the alerting flags; lower temp and supply-high stay silent
    next_fault_alert = next_flags[fmpc_pkg::FLT_ILOW] | next_flags[fmpc_pkg::FLT_IHIGH]
                     | next_flags[fmpc_pkg::FLT_THIGH]
                     | next_flags[fmpc_pkg::FLT_SLOW];
  end

  // Sticky events: a new flag wins over a same-cycle clear
  assign rising = next_flags & ~flags;
  always_comb begin
    next_status = status;
    next_mask   = mask;
    next_control = control;
    if (wr_en && paddr == fmpc_pkg::ADDR_STATUS) begin
      next_status = status & ~pwdata[5:0];
    end
    next_status = next_status | rising;
    if (wr_en && paddr == fmpc_pkg::ADDR_MASK) begin
      next_mask = pwdata[5:0];
    end
    if (wr_en && paddr == fmpc_pkg::ADDR_CONTROL) begin
      next_control = {pwdata[fmpc_pkg::CTL_ADC_SEL], pwdata[fmpc_pkg::CTL_ADC_PWR], 7'h00};
    end
  end

  // One-shot conversion sequencer
  always_comb begin
    next_state    = state;
    next_conv_cnt = conv_cnt;
    next_result   = result;
    case (state)
      fmpc_pkg::FMPC_IDLE: begin
        if (cmd_hit) begin
          next_state    = fmpc_pkg::FMPC_CONV;
          next_conv_cnt = 8'(fmpc_pkg::CONV_CYCLES - 1);
        end
      end
      fmpc_pkg::FMPC_CONV: begin
        if (conv_cnt == 8'h00) begin
          next_state = fmpc_pkg::FMPC_DONE;
        end else begin
          next_conv_cnt = conv_cnt - 8'h01;
        end
      end
      fmpc_pkg::FMPC_DONE: begin
        next_result = adc_result;
        next_state  = fmpc_pkg::FMPC_IDLE;
      end
      default: begin
        next_state = fmpc_pkg::FMPC_IDLE;
      end
    endcase
  end

  // Converter powered while the bit is set or a single conversion runs
  assign adc_power      = control[fmpc_pkg::CTL_ADC_PWR] || (state != fmpc_pkg::FMPC_IDLE);
  assign adc_input_temp = control[fmpc_pkg::CTL_ADC_SEL];
  assign adc_start      = (state == fmpc_pkg::FMPC_CONV) && (conv_cnt == 8'(fmpc_pkg::CONV_CYCLES - 1));

  // Strap decode; straps are static, so decode is plain logic
  always_comb begin
    case ({range_strap_msb, range_strap_lsb})
      2'b00:   loop_range = fmpc_pkg::RANGE_4_20;
      2'b10:   loop_range = fmpc_pkg::RANGE_32_24;
      default: loop_range = fmpc_pkg::RANGE_38_21;
    endcase
    regulator_output     = {regulator_strap_bit2, regulator_strap_bit1, regulator_strap_bit0};
    regulator_code_valid = (regulator_output != 3'b111);
  end

  assign irq = |(status & mask);

  // Register all state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags       <= 6'h00;
      fault_alert <= 1'b0;
      control     <= fmpc_pkg::CONTROL_RESET;
      status      <= 6'h00;
      mask        <= fmpc_pkg::MASK_RESET;
      result      <= 8'h00;
      state       <= fmpc_pkg::FMPC_IDLE;
      conv_cnt    <= 8'h00;
    end else begin
      flags       <= next_flags;
      fault_alert <= next_fault_alert;
      control     <= next_control;
      status      <= next_status;
      mask        <= next_mask;
      result      <= next_result;
      state       <= next_state;
      conv_cnt    <= next_conv_cnt;
    end
  end

  // Assertions
  property p_alert_current;
    @(posedge ref_clk) disable iff (!rst_n)
      (flags[0] || flags[1]) |-> fault_alert;
  endproperty
  a_alert_current: assert property (p_alert_current) else $error("current flag without alert");

  property p_temp_low_silent;
    @(posedge ref_clk) disable iff (!rst_n)
      (flags == 6'b000100) |-> !fault_alert;
  endproperty
  a_temp_low_silent: assert property (p_temp_low_silent) else $error("lower temp raised alert");

  property p_supply_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (flags[4] && !cmp_sync[5]) |=> flags[4];
  endproperty
  a_supply_hold: assert property (p_supply_hold) else $error("supply high flag dropped early");

  property p_supply_low_alert;
    @(posedge ref_clk) disable iff (!rst_n)
      flags[5] |-> fault_alert;
  endproperty
  a_supply_low_alert: assert property (p_supply_low_alert) else $error("supply low without alert");

  property p_current_flag;
    @(posedge ref_clk) disable iff (!rst_n)
      cmp_sync[0] |=> flags[0];
  endproperty
  a_current_flag: assert property (p_current_flag) else $error("current low not flagged");

  property p_temp_flag;
    @(posedge ref_clk) disable iff (!rst_n)
      cmp_sync[3] |=> flags[3] ##0 fault_alert;
  endproperty
  a_temp_flag: assert property (p_temp_flag) else $error("upper temp not flagged");

  property p_convert;
    @(posedge ref_clk) disable iff (!rst_n)
      (cmd_hit && state == fmpc_pkg::FMPC_IDLE) |=> adc_power ##[1:40] state == fmpc_pkg::FMPC_DONE;
  endproperty
  a_convert: assert property (p_convert) else $error("conversion did not run");

  property p_result;
    @(posedge ref_clk) disable iff (!rst_n)
      (state == fmpc_pkg::FMPC_DONE) |=> result == $past(adc_result);
  endproperty
  a_result: assert property (p_result) else $error("result not captured");

  property p_power;
    @(posedge ref_clk) disable iff (!rst_n)
      control[7] |-> adc_power;
  endproperty
  a_power: assert property (p_power) else $error("converter not powered");

  // Supply-high flag on its own must stay off the alert pin
  property p_supply_high_silent;
    @(posedge ref_clk) disable iff (!rst_n)
      (flags == 6'b010000) |-> !fault_alert;
  endproperty
  a_supply_high_silent: assert property (p_supply_high_silent) else $error("supply high raised alert");

  // Both straps high repeats the middle range
  property p_range_repeat;
    @(posedge ref_clk) disable iff (!rst_n)
      ({range_strap_msb, range_strap_lsb} == 2'b11) |-> (loop_range == fmpc_pkg::RANGE_38_21);
  endproperty
  a_range_repeat: assert property (p_range_repeat) else $error("range straps high-high misdecoded");

  // The undefined regulator code is flagged
  property p_reg_invalid;
    @(posedge ref_clk) disable iff (!rst_n)
      (regulator_output == 3'b111) |-> !regulator_code_valid;
  endproperty
  a_reg_invalid: assert property (p_reg_invalid) else $error("undefined regulator code accepted");

  // A started conversion always has the converter powered
  property p_start_powered;
    @(posedge ref_clk) disable iff (!rst_n)
      adc_start |-> adc_power;
  endproperty
  a_start_powered: assert property (p_start_powered) else $error("conversion started unpowered");
endmodule

// >>> rtl/fmpc_pkg.sv
package fmpc_pkg;
  // Register byte offsets on the APB bus
  localparam logic [7:0] ADDR_FAULT    = 8'h00;  // Fault flags and last conversion, read
  localparam logic [7:0] ADDR_CONTROL  = 8'h04;  // Converter power and input select
  localparam logic [7:0] ADDR_COMMAND  = 8'h08;  // Command byte, write
  localparam logic [7:0] ADDR_STATUS   = 8'h0C;  // Sticky event bits, write one to clear
  localparam logic [7:0] ADDR_MASK     = 8'h10;  // Interrupt mask
  localparam logic [7:0] ADDR_STRAPS   = 8'h14;  // Decoded strap settings, read

  // Fault register field positions
  localparam int FLT_ILOW   = 0;   // Loop current below programmed
  localparam int FLT_IHIGH  = 1;   // Loop current above programmed
  localparam int FLT_TLOW   = 2;   // Die above lower temperature threshold
  localparam int FLT_THIGH  = 3;   // Die above upper temperature threshold
  localparam int FLT_SHIGH  = 4;   // Supply below high threshold
  localparam int FLT_SLOW   = 5;   // Supply below low threshold
  localparam int NUM_FLAGS  = 6;
  localparam int FLT_RESULT = 8;   // Conversion result at bits 15:8

  // Control register field positions
  localparam int CTL_ADC_PWR = 7;  // Keep converter powered
  localparam int CTL_ADC_SEL = 8;  // 1 selects die temperature, 0 loop sense

  // Command byte that starts one conversion
  localparam logic [7:0] CMD_CONVERT = 8'h08;

  // Reset values
  localparam logic [8:0] CONTROL_RESET = 9'h000;
  localparam logic [5:0] MASK_RESET    = 6'h00;

  // Conversion time
  localparam int CLK_HZ         = 20_000_000;
  localparam int CONV_TIME_NS   = 1000;
  localparam int CONV_CYCLES    = (CONV_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // Loop current range encodings
  localparam logic [1:0] RANGE_4_20  = 2'd0;
  localparam logic [1:0] RANGE_38_21 = 2'd1;
  localparam logic [1:0] RANGE_32_24 = 2'd2;

  // Converter sequencer states, Gray along idle-convert-done
  typedef enum logic [1:0] {
    FMPC_IDLE = 2'b00,
    FMPC_CONV = 2'b01,
    FMPC_DONE = 2'b11
  } fmpc_state_e;
endpackage

// >>> rtl/fmpc_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a bundle of asynchronous comparator levels
module fmpc_sync #(
  parameter int W = 6
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1;  // Metastable stage, read only by stage two

  // Each bit gets its own pair; no bit depends on another
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          stage1[i] <= 1'b0;
          dout[i]   <= 1'b0;
        end else begin
          stage1[i] <= din[i];
          dout[i]   <= stage1[i];
        end
      end
    end
  endgenerate
endmodule

// >>> test/fmpc_front_model.sv
`timescale 1ns/1ps
// Analog front end behind the block: comparators and converter
module fmpc_front_model #(
  parameter int T_LOW  = 100,
  parameter int T_HIGH = 140
) (
  input  wire logic        ref_clk,
  input  wire logic [15:0] sense_mv,
  input  wire logic [15:0] temp_c,
  input  wire logic        adc_start,
  input  wire logic        adc_input_temp,
  output logic             cmp_temp_lower,
  output logic             cmp_temp_upper,
  output logic             cmp_sense_below_0v6,
  output logic             cmp_sense_above_0v7,
  output logic             cmp_sense_below_0v3,
  output logic             cmp_sense_above_0v4,
  output logic [7:0]       adc_result
);
  // Sense thresholds in mV; the gaps between the sense pairs give the hysteresis
  assign cmp_temp_lower      = temp_c > T_LOW;
  assign cmp_temp_upper      = temp_c > T_HIGH;
  assign cmp_sense_below_0v6 = sense_mv < 16'h0258;
  assign cmp_sense_above_0v7 = sense_mv > 16'h02BC;
  assign cmp_sense_below_0v3 = sense_mv < 16'h012C;
  assign cmp_sense_above_0v4 = sense_mv > 16'h0190;
  // Result frozen at start so it cannot move while captured
  always_ff @(posedge ref_clk) begin
    if (adc_start) adc_result <= adc_input_temp ? temp_c[7:0] : 8'(sense_mv / 16'h000A);
  end
endmodule

// >>> test/fmpc_top_tb.sv
`timescale 1ns/1ps
// Self-checking bench acting as APB host
module fmpc_top_tb;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, adc_result;
  logic [31:0] pwdata, prdata;
  logic        cmp_current_below, cmp_current_above, cmp_temp_lower, cmp_temp_upper;
  logic        cmp_sense_below_0v6, cmp_sense_above_0v7, cmp_sense_below_0v3, cmp_sense_above_0v4;
  logic        adc_power, adc_input_temp, adc_start, fault_alert, irq, regulator_code_valid;
  logic        range_strap_lsb, range_strap_msb, regulator_strap_bit0, regulator_strap_bit1, regulator_strap_bit2;
  logic [1:0]  loop_range;
  logic [2:0]  regulator_output;
  logic [15:0] sense_mv, temp_c;
  int          mismatches = 0;
  int          compares = 0;

  fmpc_top dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cmp_current_below, .cmp_current_above, .cmp_temp_lower, .cmp_temp_upper, .cmp_sense_below_0v6,
    .cmp_sense_above_0v7, .cmp_sense_below_0v3, .cmp_sense_above_0v4, .adc_result, .adc_power,
    .adc_input_temp, .adc_start, .range_strap_lsb, .range_strap_msb, .regulator_strap_bit0,
    .regulator_strap_bit1, .regulator_strap_bit2, .loop_range, .regulator_output,
    .regulator_code_valid, .fault_alert, .irq);

  fmpc_front_model afe (.ref_clk, .sense_mv, .temp_c, .adc_start, .adc_input_temp, .cmp_temp_lower,
    .cmp_temp_upper, .cmp_sense_below_0v6, .cmp_sense_above_0v7, .cmp_sense_below_0v3,
    .cmp_sense_above_0v4, .adc_result);

  // 50 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t %s got %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Bounded wait ran out: count it and stop
  task automatic guard(input int n);
    if (n >= 100) begin
      mismatches++;
      conclude();
    end
  endtask

  // One APB transfer; held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    guard(n);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
    logic [31:0] r;
    logic        x;
    apb(1'b0, a, 32'h0000_0000, r, x);
    check(r & m, e, s);
  endtask

  task automatic t_reset();
    rdchk(fmpc_pkg::ADDR_CONTROL, 32'h0000_0180, 32'h0000_0000, "control reset");
    rdchk(fmpc_pkg::ADDR_MASK, 32'h0000_003F, 32'h0000_0000, "mask reset");
    check(fault_alert, 1'h0, "alert reset");
  endtask

  task automatic t_current();
    for (int i = 0; i < 2; i++) begin
      cmp_current_below <= (i == 0); cmp_current_above <= (i == 1);
      cyc(5);
      check(fault_alert, 1'h1, "current alert");
      rdchk(fmpc_pkg::ADDR_FAULT, 32'h0000_0003, i + 1, "current flag");
    end
    cmp_current_above <= 1'b0;
    cyc(5);
    check(fault_alert, 1'h0, "alert released");
  endtask

  task automatic t_temp();
    temp_c <= 16'h0078;
    cyc(5);
    rdchk(fmpc_pkg::ADDR_FAULT, 32'h0000_000C, 32'h0000_0004, "lower temp");
    check(fault_alert, 1'h0, "lower temp no alert");
    temp_c <= 16'h0096;
    cyc(5);
    rdchk(fmpc_pkg::ADDR_FAULT, 32'h0000_000C, 32'h0000_000C, "upper temp");
    check(fault_alert, 1'h1, "upper temp alert");
    temp_c <= 16'h005A;
    cyc(5);
  endtask

  // Walk the sense level across both hysteresis bands
  task automatic t_supply();
    logic [15:0] mv[7] = '{16'h0226, 16'h028A, 16'h02EE, 16'h00FA, 16'h015E, 16'h01C2, 16'h02EE};
    logic [1:0]  ex[7] = '{2'h1, 2'h1, 2'h0, 2'h3, 2'h3, 2'h1, 2'h0};
    for (int i = 0; i < 7; i++) begin
      sense_mv <= mv[i];
      cyc(5);
      rdchk(fmpc_pkg::ADDR_FAULT, 32'h0000_0030, {ex[i], 4'h0}, "supply flags");
      check(fault_alert, ex[i][1], "supply alert");
    end
  endtask

  task automatic t_straps();
    for (int i = 0; i < 4; i++) begin
      {range_strap_msb, range_strap_lsb} <= 2'(i);
      cyc(1);
      check(loop_range, (i == 2) ? 2'h2 : (i == 0) ? 2'h0 : 2'h1, "range");
    end
    for (int i = 0; i < 8; i++) begin
      {regulator_strap_bit2, regulator_strap_bit1, regulator_strap_bit0} <= 3'(i);
      cyc(1);
      check(regulator_code_valid, i != 7, "reg valid");
      if (i < 7) check(regulator_output, i, "reg code");
    end
    // Range straps high-high and regulator code 7 as seen over the bus
    rdchk(fmpc_pkg::ADDR_STRAPS, 32'h0000_003F, 32'h0000_001D, "straps read");
  endtask

  task automatic t_adc();
    int   n;
    logic seen;
    wr(fmpc_pkg::ADDR_CONTROL, 32'h0000_0100);
    cyc(1);
    check(adc_input_temp, 1'h1, "select temp");
    cyc(600);
    seen = 1'b0;
    wr(fmpc_pkg::ADDR_COMMAND, 32'h0000_0009);
    for (n = 0; n < 30; n++) begin
      cyc(1);
      seen |= adc_start;
    end
    check(seen, 1'h0, "bad command ignored");
    wr(fmpc_pkg::ADDR_COMMAND, {24'h00_0000, fmpc_pkg::CMD_CONVERT});
    for (n = 0; n < 100 && adc_start !== 1'b1; n++) cyc(1);
    guard(n);
    check(adc_power, 1'h1, "powered in conversion");
    for (n = 0; n < 100 && adc_power !== 1'b0; n++) cyc(1);
    guard(n);
    cyc(3);
    rdchk(fmpc_pkg::ADDR_FAULT, 32'h0000_FF00, 32'h0000_5A00, "result");
    wr(fmpc_pkg::ADDR_CONTROL, 32'h0000_0080);
    cyc(1);
    check(adc_power, 1'h1, "power bit");
    check(adc_input_temp, 1'h0, "select loop sense");
    // Loop sense held at 750 mV converts to 75
    wr(fmpc_pkg::ADDR_COMMAND, {24'h00_0000, fmpc_pkg::CMD_CONVERT});
    cyc(fmpc_pkg::CONV_CYCLES + 4);
    rdchk(fmpc_pkg::ADDR_FAULT, 32'h0000_FF00, 32'h0000_4B00, "loop sense result");
    wr(fmpc_pkg::ADDR_CONTROL, 32'h0000_0000);
    cyc(1);
    check(adc_power, 1'h0, "power off");
  endtask

  task automatic t_irq();
    logic [31:0] r;
    logic        e;
    wr(fmpc_pkg::ADDR_STATUS, 32'h0000_003F);
    wr(fmpc_pkg::ADDR_MASK, 32'h0000_0001);
    cmp_current_above <= 1'b1;
    cyc(5);
    check(irq, 1'h0, "masked event");
    cmp_current_above <= 1'b0; cmp_current_below <= 1'b1;
    cyc(5);
    check(irq, 1'h1, "irq raised");
    cmp_current_below <= 1'b0;
    cyc(5);
    rdchk(fmpc_pkg::ADDR_STATUS, 32'h0000_0003, 32'h0000_0003, "sticky status");
    wr(fmpc_pkg::ADDR_STATUS, 32'h0000_0001);
    cyc(1);
    check(irq, 1'h0, "irq cleared");
    apb(1'b0, 8'h20, 32'h0000_0000, r, e);
    check({r[30:0], e}, 32'h0000_0001, "unmapped");
  endtask

  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
    cmp_current_below = 1'b0; cmp_current_above = 1'b0; sense_mv = 16'h03E8; temp_c = 16'h005A;
    range_strap_lsb = 1'b0; range_strap_msb = 1'b0;
    {regulator_strap_bit2, regulator_strap_bit1, regulator_strap_bit0} = 3'h0;
    cyc(4);
    rst_n <= 1'b1;
    t_reset();
    t_current();
    t_temp();
    t_supply();
    t_straps();
    t_adc();
    t_irq();
    conclude();
  end
endmodule
